// *** core/lcd_pkg.sv ***
// lcd_pkg: constants and types of the lcd command decoder
// assumes a single 10 MHz system clock and a synchronous active-high reset
package lcd_pkg;
   // ------------------------------------------------------------
   // timing
   // ------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 100;
   localparam int BLINK_HALF_MS = 500; // half of the ~1 s blink period
   localparam int BLINK_HALF_CYC = BLINK_HALF_MS * 1000000 / CLK_PERIOD_NS;
   localparam int FIFO_DEPTH = 4;
   localparam int FIFO_WIDTH = 9;
   // ------------------------------------------------------------
   // addresses and opcodes
   // ------------------------------------------------------------
   localparam logic [6:0] ADDR_HOME = 7'h30;
   localparam logic [6:0] ADDR_RESET = 7'h00;
   localparam logic [6:0] ADDR_ICON = 7'h20;
   localparam logic [6:0] ADDR_ICON_END = 7'h23;
   localparam logic [6:0] ADDR_CONTRAST = 7'h28;
   localparam logic [6:0] ADDR_TEST = 7'h29;
   localparam logic [6:0] ADDR_LED = 7'h2A;
   localparam logic [6:0] ADDR_LINE1 = 7'h30;
   localparam logic [6:0] ADDR_LINE2 = 7'h40;
   localparam logic [6:0] ADDR_LINE3 = 7'h50;
   localparam logic [6:0] ADDR_SYMBOL = 7'h60;
   localparam logic [3:0] OP_TEST = 4'h0;
   localparam logic [3:0] OP_HOME = 4'h1;
   localparam logic [3:0] OP_DISPLAY = 4'h3;
   localparam logic [3:0] OP_PSAVE = 4'h4;
   localparam logic [3:0] OP_POWER = 4'h5;
   localparam logic [3:0] OP_SETUP = 4'h6;
   localparam logic [7:0] GLYPH_USER_LAST = 8'h03;
   localparam int BIT_ADDR_CMD = 7;
   localparam logic [1:0] LINE_NONE = 2'h0;
   localparam logic [1:0] LINE_ONE = 2'h1;
   localparam logic [1:0] LINE_TWO = 2'h2;
   localparam logic [1:0] LINE_THREE = 2'h3;
   // ------------------------------------------------------------
   // types
   // ------------------------------------------------------------
   typedef struct packed {
      logic is_data;   // data/command select at the write
      logic [7:0] value;
   } lcd_byte_s;
   typedef struct packed {
      logic cursor_visible;
      logic cursor_blink;
      logic tall_glyph_flag;
      logic display_on;
   } lcd_disp_s;
   localparam lcd_disp_s DISP_RESET = 4'h0;
   typedef struct packed {
      logic two_lines;
      logic mirror_horizontal;
      logic mirror_vertical;
      logic user_glyph_enable;
   } lcd_setup_s;
   localparam lcd_setup_s SETUP_RESET = 4'h0;
   typedef enum logic [1:0] {
      CUR_OFF = 2'h0,
      CUR_UNDERBAR = 2'h1,
      CUR_BLINK = 2'h2
   } lcd_cursor_e;
   typedef enum logic [3:0] {
      REG_USER_GLYPH = 4'h0,
      REG_ICON = 4'h1,
      REG_CONTRAST = 4'h2,
      REG_TEST = 4'h3,
      REG_LED = 4'h4,
      REG_LINE1 = 4'h5,
      REG_LINE2 = 4'h6,
      REG_LINE3 = 4'h7,
      REG_SYMBOL = 4'h8,
      REG_UNUSED = 4'h9
   } lcd_region_e;
   typedef enum logic {
      ST_IDLE = 1'b0,
      ST_EXEC = 1'b1
   } lcd_state_e;
endpackage

// *** core/lcd_fifo.sv ***
// lcd_fifo: small synchronous fifo with valid/ready on both sides
// assumes one clock and a synchronous active-high reset
`timescale 1ns/1ns
module lcd_fifo #(
   parameter int WIDTH = 9,
   parameter int DEPTH = 4
) (
   input wire logic sys_clk,            // system clock
   input wire logic rst,                // sync reset, high
   input wire logic in_valid,           // write request
   output logic in_ready,               // room for one more word
   input wire logic [WIDTH-1:0] in_data, // word written
   output logic out_valid,              // a word is waiting
   input wire logic out_ready,          // reader takes the word
   output logic [WIDTH-1:0] out_data    // oldest word
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] wr_ptr;
   logic [AW-1:0] rd_ptr;
   logic [AW:0] count;
   logic do_wr;
   logic do_rd;

   // handshakes; full and empty follow the occupancy count
   assign in_ready = (count != (AW+1)'(DEPTH));
   assign out_valid = (count != '0);
   assign do_wr = in_valid && in_ready;
   assign do_rd = out_valid && out_ready;
   assign out_data = mem[rd_ptr];

   // storage, no reset needed for the array
   always_ff @(posedge sys_clk) begin
      if (do_wr) begin
         mem[wr_ptr] <= in_data;
      end
   end

   // pointers wrap at the depth, which need not be a power of two
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count <= '0;
      end else begin
         if (do_wr) begin
            wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + AW'(1);
         end
         if (do_rd) begin
            rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + AW'(1);
         end
         count <= count + (AW+1)'(do_wr) - (AW+1)'(do_rd);
      end
   end
endmodule // lcd_fifo

// *** core/lcd_command_decoder.sv ***
// lcd_command_decoder: host byte capture, command decode, address counter
// and display control state of a character lcd controller
// assumes host pins already synchronous to sys_clk and a sync reset
//
// Function
// - cursor home loads the address counter with 30H.
// - display opcode 0011 carries cursor, blink, tall, display flags in bits 3..0.
// - display flag blanks or shows text; tall flag picks double height.
// - tall in three lines spans line3 over 2-3; two lines, line1 over 1-2.
// - cursor off unless visible; visible gives underbar, with blink reversing.
// - cursor blink toggles normal and reversed with about one second period.
// - power save opcode 0100, bit 1 runs the oscillator, bits 3-2 ignored.
// - power save bit 0 selects the low-power state when 1.
// - power control bit 0 enables the built-in lcd supply.
// - line-count bit 0 gives three lines 1/26, 1 gives two lines 1/18.
// - two mirror bits pick normal, left-right, top-bottom or rotated view.
// - user glyph enable routes codes 00H-03H to user glyph memory.
// - command with bit 7 set loads seven low bits into the address counter.
// - data bytes store at the counter, then the counter advances by one.
// - the cursor sits at the current address counter value.
// - all-zero command is a no-operation.
// - data/command select high means data, low means command.
// - reset clears all display, power, setup and orientation bits.
`timescale 1ns/1ns
module lcd_command_decoder #(
   parameter int BLINK_HALF = lcd_pkg::BLINK_HALF_CYC // cycles per blink half
) (
   input wire logic sys_clk,                 // 10 MHz system clock
   input wire logic rst,                     // sync reset, high
   input wire logic chip_select_n,           // host port select, low
   input wire logic write_strobe_n,          // write strobe, byte taken on fall
   input wire logic data_command_select,     // 1 data, 0 command
   input wire logic [7:0] host_data,         // host data bus
   output logic host_busy,                   // byte buffer full or a byte pushed without a pop, hold writes
   output logic mem_write,                   // one-cycle memory write
   output logic [6:0] mem_addr,              // memory write address
   output logic [7:0] mem_data,              // memory write data
   output lcd_pkg::lcd_region_e mem_region,  // region of the write
   output logic [6:0] cursor_addr,           // address counter / cursor spot
   output lcd_pkg::lcd_cursor_e cursor_style, // cursor rendering
   output logic cursor_reverse,              // blink phase, reversed when 1
   output logic display_on,                  // text shown
   output logic tall_glyph_flag,             // double-height text
   output logic [1:0] tall_source_line,      // line drawn double, 0 none
   output logic [1:0] tall_top_line,         // top line of the double span
   output logic osc_enable,                  // oscillator runs
   output logic low_power_select,            // low-power state
   output logic supply_enable,               // built-in lcd supply on
   output logic two_lines,                   // 1 two lines 1/18, 0 three 1/26
   output logic mirror_horizontal,           // left-right mirror
   output logic mirror_vertical,             // top-bottom mirror
   input wire logic [7:0] glyph_code,        // code being rendered
   output logic glyph_from_user              // fetch glyph from user memory
);
   // ------------------------------------------------------------
   // host byte capture and buffering
   // ------------------------------------------------------------
   logic strobe_prev;
   logic push;
   logic in_ready;
   logic out_valid;
   logic pop;
   lcd_pkg::lcd_byte_s push_byte;
   lcd_pkg::lcd_byte_s head_byte;
   lcd_pkg::lcd_byte_s cur_byte;
   lcd_pkg::lcd_state_e state;
   lcd_pkg::lcd_disp_s disp;
   lcd_pkg::lcd_setup_s setup;
   logic [6:0] addr_cnt;
   logic [3:0] opcode;
   logic is_cmd;
   logic blink_run;
   logic [$clog2(BLINK_HALF+1)-1:0] blink_cnt;
   lcd_pkg::lcd_region_e next_region;

   // previous strobe level for fall detection
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         strobe_prev <= 1'b1;
      end else begin
         strobe_prev <= write_strobe_n;
      end
   end

   // a byte is offered on the strobe fall while selected
   assign push = strobe_prev && !write_strobe_n && !chip_select_n;
   assign push_byte = '{is_data: data_command_select, value: host_data};

   lcd_fifo #(
      .WIDTH(lcd_pkg::FIFO_WIDTH),
      .DEPTH(lcd_pkg::FIFO_DEPTH)
   ) u_fifo (
      .sys_clk(sys_clk),
      .rst(rst),
      .in_valid(push),
      .in_ready(in_ready),
      .in_data(push_byte),
      .out_valid(out_valid),
      .out_ready(pop),
      .out_data(head_byte)
   );

   // busy is registered; the host must watch it, a write while full is lost
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         host_busy <= 1'b0;
      end else begin
         host_busy <= !in_ready || (push && in_ready && !pop);
      end
   end

   // ------------------------------------------------------------
   // execution sequencer
   // ------------------------------------------------------------
   // one idle cycle per byte gives each instruction its processing slot
   assign pop = (state == lcd_pkg::ST_IDLE) && out_valid;

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         state <= lcd_pkg::ST_IDLE;
         cur_byte <= '0;
      end else begin
         unique case (state)
            lcd_pkg::ST_IDLE: begin
               if (out_valid) begin
                  cur_byte <= head_byte;
                  state <= lcd_pkg::ST_EXEC;
               end
            end
            lcd_pkg::ST_EXEC: begin
               state <= lcd_pkg::ST_IDLE;
            end
         endcase
      end
   end

   assign opcode = cur_byte.value[7:4];
   assign is_cmd = (state == lcd_pkg::ST_EXEC) && !cur_byte.is_data;

   // ------------------------------------------------------------
   // address counter and memory writes
   // ------------------------------------------------------------
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         addr_cnt <= lcd_pkg::ADDR_RESET;
      end else if (state == lcd_pkg::ST_EXEC) begin
         if (cur_byte.is_data) begin
            addr_cnt <= addr_cnt + 7'h01; // wraps at 7FH
         end else if (cur_byte.value[lcd_pkg::BIT_ADDR_CMD]) begin
            addr_cnt <= cur_byte.value[6:0];
         end else if (opcode == lcd_pkg::OP_HOME) begin
            addr_cnt <= lcd_pkg::ADDR_HOME;
         end
      end
   end

   // region of an address for the memory side
   always_comb begin
      if (addr_cnt < lcd_pkg::ADDR_ICON) begin
         next_region = lcd_pkg::REG_USER_GLYPH;
      end else if (addr_cnt <= lcd_pkg::ADDR_ICON_END) begin
         next_region = lcd_pkg::REG_ICON;
      end else if (addr_cnt == lcd_pkg::ADDR_CONTRAST) begin
         next_region = lcd_pkg::REG_CONTRAST;
      end else if (addr_cnt == lcd_pkg::ADDR_TEST) begin
         next_region = lcd_pkg::REG_TEST;
      end else if (addr_cnt == lcd_pkg::ADDR_LED) begin
         next_region = lcd_pkg::REG_LED;
      end else if (addr_cnt < lcd_pkg::ADDR_LINE1) begin
         next_region = lcd_pkg::REG_UNUSED;
      end else if (addr_cnt < lcd_pkg::ADDR_LINE2) begin
         next_region = lcd_pkg::REG_LINE1;
      end else if (addr_cnt < lcd_pkg::ADDR_LINE3) begin
         next_region = lcd_pkg::REG_LINE2;
      end else if (addr_cnt < lcd_pkg::ADDR_SYMBOL) begin
         next_region = lcd_pkg::REG_LINE3;
      end else begin
         next_region = lcd_pkg::REG_SYMBOL;
      end
   end

   // data byte lands at the counter before it advances
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         mem_write <= 1'b0;
         mem_addr <= lcd_pkg::ADDR_RESET;
         mem_data <= 8'h00;
         mem_region <= lcd_pkg::REG_USER_GLYPH;
      end else begin
         mem_write <= (state == lcd_pkg::ST_EXEC) && cur_byte.is_data;
         if ((state == lcd_pkg::ST_EXEC) && cur_byte.is_data) begin
            mem_addr <= addr_cnt;
            mem_data <= cur_byte.value;
            mem_region <= next_region;
         end
      end
   end

   // ------------------------------------------------------------
   // control bits set by commands
   // ------------------------------------------------------------
   // all-zero and test opcodes fall through and leave every bit alone
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         disp <= lcd_pkg::DISP_RESET;
      end else if (is_cmd && opcode == lcd_pkg::OP_DISPLAY) begin
         disp <= cur_byte.value[3:0];
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         osc_enable <= 1'b0;
         low_power_select <= 1'b0;
      end else if (is_cmd && opcode == lcd_pkg::OP_PSAVE) begin
         osc_enable <= cur_byte.value[1];
         low_power_select <= cur_byte.value[0];
      end
   end

   // power opcode only with its three spare bits at zero
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         supply_enable <= 1'b0;
      end else if (is_cmd && opcode == lcd_pkg::OP_POWER && cur_byte.value[3:1] == 3'h0) begin
         supply_enable <= cur_byte.value[0];
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         setup <= lcd_pkg::SETUP_RESET;
      end else if (is_cmd && opcode == lcd_pkg::OP_SETUP) begin
         setup <= cur_byte.value[3:0];
      end
   end

   // ------------------------------------------------------------
   // display outputs derived from control state
   // ------------------------------------------------------------
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         display_on <= 1'b0;
         tall_glyph_flag <= 1'b0;
         two_lines <= 1'b0;
         mirror_horizontal <= 1'b0;
         mirror_vertical <= 1'b0;
         cursor_addr <= lcd_pkg::ADDR_RESET;
         glyph_from_user <= 1'b0;
      end else begin
         display_on <= disp.display_on;
         tall_glyph_flag <= disp.tall_glyph_flag;
         two_lines <= setup.two_lines;
         mirror_horizontal <= setup.mirror_horizontal;
         mirror_vertical <= setup.mirror_vertical;
         cursor_addr <= addr_cnt;
         glyph_from_user <= setup.user_glyph_enable
            && (glyph_code <= lcd_pkg::GLYPH_USER_LAST);
      end
   end

   // double-height span follows the line count
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         tall_source_line <= lcd_pkg::LINE_NONE;
         tall_top_line <= lcd_pkg::LINE_NONE;
      end else if (!disp.tall_glyph_flag) begin
         tall_source_line <= lcd_pkg::LINE_NONE;
         tall_top_line <= lcd_pkg::LINE_NONE;
      end else if (setup.two_lines) begin
         tall_source_line <= lcd_pkg::LINE_ONE;
         tall_top_line <= lcd_pkg::LINE_ONE;
      end else begin
         tall_source_line <= lcd_pkg::LINE_THREE;
         tall_top_line <= lcd_pkg::LINE_TWO;
      end
   end

   // cursor style from visible and blink flags
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         cursor_style <= lcd_pkg::CUR_OFF;
      end else if (!disp.cursor_visible) begin
         cursor_style <= lcd_pkg::CUR_OFF;
      end else if (disp.cursor_blink) begin
         cursor_style <= lcd_pkg::CUR_BLINK;
      end else begin
         cursor_style <= lcd_pkg::CUR_UNDERBAR;
      end
   end

   // ------------------------------------------------------------
   // cursor blink timer
   // ------------------------------------------------------------
   // phase restarts normal whenever blinking stops, so the first look is upright
   assign blink_run = disp.cursor_visible && disp.cursor_blink;

   always_ff @(posedge sys_clk) begin
      if (rst || !blink_run) begin
         blink_cnt <= '0;
         cursor_reverse <= 1'b0;
      end else if (blink_cnt == $bits(blink_cnt)'(BLINK_HALF - 1)) begin
         blink_cnt <= '0;
         cursor_reverse <= !cursor_reverse;
      end else begin
         blink_cnt <= blink_cnt + 1'b1;
      end
   end

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   property p_home;
      @(posedge sys_clk) disable iff (rst)
      (is_cmd && cur_byte.value[7:4] == 4'h1) |=> (addr_cnt == 7'h30);
   endproperty
   a_home: assert property (p_home) else $error("home did not load 30H");

   property p_addr_load;
      @(posedge sys_clk) disable iff (rst)
      (is_cmd && cur_byte.value[7]) |=> (addr_cnt == $past(cur_byte.value[6:0]));
   endproperty
   a_addr_load: assert property (p_addr_load) else $error("address load wrong");

   property p_data_write;
      @(posedge sys_clk) disable iff (rst)
      (state == lcd_pkg::ST_EXEC && cur_byte.is_data) |=>
         (mem_write && mem_addr == $past(addr_cnt) && addr_cnt == $past(addr_cnt) + 7'h01);
   endproperty
   a_data_write: assert property (p_data_write) else $error("data write or step wrong");

   property p_nop;
      @(posedge sys_clk) disable iff (rst)
      (is_cmd && cur_byte.value == 8'h00) |=>
         ($stable(disp) && $stable(setup) && $stable(addr_cnt) && $stable(supply_enable));
   endproperty
   a_nop: assert property (p_nop) else $error("nop changed state");

   property p_cursor_follow;
      @(posedge sys_clk) disable iff (rst)
      $changed(addr_cnt) |=> (cursor_addr == $past(addr_cnt));
   endproperty
   a_cursor_follow: assert property (p_cursor_follow) else $error("cursor lags counter");

   property p_cursor_off;
      @(posedge sys_clk) disable iff (rst)
      !disp.cursor_visible [*2] |-> (cursor_style == lcd_pkg::CUR_OFF && !cursor_reverse);
   endproperty
   a_cursor_off: assert property (p_cursor_off) else $error("cursor shown while off");

   property p_power_save;
      @(posedge sys_clk) disable iff (rst)
      (is_cmd && cur_byte.value[7:4] == 4'h4) |=>
         (osc_enable == $past(cur_byte.value[1]) && low_power_select == $past(cur_byte.value[0]));
   endproperty
   a_power_save: assert property (p_power_save) else $error("power save bits wrong");

   property p_tall_three;
      @(posedge sys_clk) disable iff (rst)
      (disp.tall_glyph_flag && !setup.two_lines) |=>
         (tall_source_line == 2'h3 && tall_top_line == 2'h2);
   endproperty
   a_tall_three: assert property (p_tall_three) else $error("tall span wrong");

   property p_reset_clear;
      @(posedge sys_clk) rst |=> (disp == 4'h0 && setup == 4'h0 && !supply_enable && !osc_enable);
   endproperty
   a_reset_clear: assert property (p_reset_clear) else $error("reset left a bit set");
endmodule // lcd_command_decoder

// *** bench/lcd_host_model.sv ***
// lcd_host_model: behavioural host that writes command and data bytes
// assumes the bench calls send only after host_busy has been seen low
`timescale 1ns/1ns
module lcd_host_model (
   input wire logic sys_clk,         // system clock
   output logic chip_select_n,       // port select, low
   output logic write_strobe_n,      // write strobe, low
   output logic data_command_select, // 1 data, 0 command
   output logic [7:0] host_data      // host data bus
);
   // idle: deselected, bus shows the inverse of the last byte, never a stale copy
   initial begin
      chip_select_n = 1'b1;
      write_strobe_n = 1'b1;
      data_command_select = 1'b0;
      host_data = 8'hFF;
   end
   // one byte: strobe low across one edge, then a gap for internal processing
   task automatic send(input logic dc, input logic [7:0] v);
      @(posedge sys_clk);
      #10;
      chip_select_n = 1'b0;
      data_command_select = dc;
      host_data = v;
      write_strobe_n = 1'b0;
      @(posedge sys_clk);
      #10;
      write_strobe_n = 1'b1;
      chip_select_n = 1'b1;
      data_command_select = ~dc;
      host_data = ~v;
      repeat (6) @(posedge sys_clk);
   endtask
endmodule // lcd_host_model

// *** bench/testbench.sv ***
// testbench: command and data sequences through the host model and the byte buffer
// assumes a 10 MHz clock and a short blink half period set by parameter
`timescale 1ns/1ns
module testbench;
   localparam int BH = 8; // short blink half keeps the run brief
   logic sys_clk, rst, cs_n, wr_n, dcs, busy, mem_write, c_rev, disp, tall, osc, lps, sup;
   logic two, mh, mv, gfu, r;
   logic [7:0] hd, mem_data, glyph_code;
   logic [6:0] mem_addr, cur, w_addr;
   logic [7:0] w_data;
   logic [1:0] src, top;
   lcd_pkg::lcd_region_e region, w_region;
   lcd_pkg::lcd_cursor_e style;
   int fail_count = 0, checks = 0, w_cnt = 0;
   logic [7:0] pw_cmd [6] = '{8'h42, 8'h4D, 8'h42, 8'h51, 8'h53, 8'h50};
   logic [2:0] pw_exp [6] = '{3'h4, 3'h2, 3'h4, 3'h5, 3'h5, 3'h4};
   initial begin
      sys_clk = 1'b0;
      forever #50 sys_clk = ~sys_clk;
   end
   lcd_host_model i_lcd_host_model (.sys_clk(sys_clk), .chip_select_n(cs_n),
      .write_strobe_n(wr_n), .data_command_select(dcs), .host_data(hd));
   lcd_command_decoder #(.BLINK_HALF(BH)) i_lcd_command_decoder (.sys_clk(sys_clk),
      .rst(rst), .chip_select_n(cs_n), .write_strobe_n(wr_n), .data_command_select(dcs),
      .host_data(hd), .host_busy(busy), .mem_write(mem_write), .mem_addr(mem_addr),
      .mem_data(mem_data), .mem_region(region), .cursor_addr(cur), .cursor_style(style),
      .cursor_reverse(c_rev), .display_on(disp), .tall_glyph_flag(tall),
      .tall_source_line(src), .tall_top_line(top), .osc_enable(osc),
      .low_power_select(lps), .supply_enable(sup), .two_lines(two),
      .mirror_horizontal(mh), .mirror_vertical(mv), .glyph_code(glyph_code),
      .glyph_from_user(gfu));
   // memory write monitor, sampled on the edge so one-cycle pulses are not missed
   always @(posedge sys_clk) begin
      if (mem_write === 1'b1) begin
         w_addr <= mem_addr;
         w_data <= mem_data;
         w_region <= region;
         w_cnt <= w_cnt + 1;
      end
   end
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
      end
   endtask
   task automatic complete_run();
      if (fail_count == 0 && checks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   // bounded wait for room, then one byte; returns settled, off the edge
   task automatic put(input logic dc, input logic [7:0] v);
      for (int k = 0; busy !== 1'b0; k++) begin
         if (k > 50) begin
            fail_count++;
            complete_run();
         end
         @(posedge sys_clk);
         #10;
      end
      i_lcd_host_model.send(dc, v);
      #10;
   endtask
   initial begin
      rst = 1'b1;
      glyph_code = 8'h00;
      repeat (2) @(posedge sys_clk);
      #10;
      rst = 1'b0;
      check({disp, tall, osc, lps, sup, two, mh, mv, cur, 1'b0}, 16'h0000);
      // every setup value, glyph codes 0..15 cover the user glyph boundary
      for (int i = 0; i < 16; i++) begin
         glyph_code = 8'(i);
         put(1'b0, 8'h60 | 8'(i));
         check({two, mh, mv}, 16'(i[3:1]));
         check(gfu, 16'(i[0] && i < 4));
      end
      // every display flag combination, two-line mode from the last setup
      for (int i = 0; i < 16; i++) begin
         put(1'b0, 8'h30 | 8'(i));
         check({disp, tall}, 16'({i[0], i[1]}));
         check(style, i[3] ? (i[2] ? lcd_pkg::CUR_BLINK : lcd_pkg::CUR_UNDERBAR)
            : lcd_pkg::CUR_OFF);
         check({src, top}, i[1] ? {lcd_pkg::LINE_ONE, lcd_pkg::LINE_ONE} : 4'h0);
      end
      r = c_rev;
      repeat (BH) @(posedge sys_clk);
      #10;
      check(c_rev, !r);
      put(1'b0, 8'h60);
      put(1'b0, 8'h32);
      check({src, top}, {lcd_pkg::LINE_THREE, lcd_pkg::LINE_TWO});
      check(c_rev, 16'h0000);
      // oscillator first, then supply; bits 3-1 set in power control are refused
      for (int i = 0; i < 6; i++) begin
         put(1'b0, pw_cmd[i]);
         check({osc, lps, sup}, pw_exp[i]);
      end
      put(1'b0, 8'hFE);
      check(cur, 16'h007E);
      put(1'b1, 8'hAA);
      check({w_addr, w_data, cur, w_region},
         {7'h7E, 8'hAA, 7'h7F, lcd_pkg::REG_SYMBOL});
      put(1'b1, 8'hBB);
      check({w_addr, w_data, cur, w_region},
         {7'h7F, 8'hBB, 7'h00, lcd_pkg::REG_SYMBOL});
      put(1'b0, 8'h1F);
      check(cur, 16'h0030);
      put(1'b0, 8'h00); // nop; the chip-test opcode is never sent
      check({cur, disp, tall, two, osc}, {7'h30, 4'h5});
      check(16'(w_cnt), 16'h0002);
      // data bytes pass the byte buffer in order into text line one
      for (int k = 0; k < 4; k++) begin
         put(1'b1, 8'h11 + 8'(k));
         check({w_addr, w_data, w_region},
            {7'h30 + 7'(k), 8'h11 + 8'(k), lcd_pkg::REG_LINE1});
      end
      check(w_cnt, 6);
      check({busy, cur}, {1'b0, 7'h34});
      complete_run();
   end
endmodule // testbench
